// *** rtl/t2wo_pkg.sv ***
/*
 * constants, field positions and carrier types for the waveform output
 * control of the 8-bit timer.
 * assumes one synchronous clock domain and an external 8-bit counter.
 */
package t2wo_pkg;

	// register offsets on the plain register port
	localparam logic [7:0] T2WO_OFS_CTRL_FIRST  = 8'hb0;
	localparam logic [7:0] T2WO_OFS_CTRL_SECOND = 8'hb1;
	localparam logic [7:0] T2WO_OFS_CMP_A       = 8'hb3;
	localparam logic [7:0] T2WO_OFS_CMP_B       = 8'hb4;
	localparam logic [7:0] T2WO_OFS_IRQ_STAT    = 8'hb7;
	localparam logic [7:0] T2WO_OFS_IRQ_MASK    = 8'hb8;

	// values after reset
	localparam logic [7:0] T2WO_RST_CTRL_FIRST  = 8'h00;
	localparam logic [7:0] T2WO_RST_CTRL_SECOND = 8'h00;
	localparam logic [7:0] T2WO_RST_CMP         = 8'h00;
	localparam logic [2:0] T2WO_RST_IRQ         = 3'h0;

	// first control register fields
	localparam int T2WO_COM_A_LSB    = 6;
	localparam int T2WO_COM_B_LSB    = 4;
	localparam int T2WO_WGM_LOW_LSB  = 0;
	localparam logic [7:0] T2WO_CTRL_FIRST_RMASK  = 8'hf3;

	// second control register fields
	localparam int T2WO_FORCE_A_BIT  = 7;
	localparam int T2WO_FORCE_B_BIT  = 6;
	localparam int T2WO_WGM_TOP_BIT  = 3;
	localparam int T2WO_CS_LSB       = 0;
	localparam logic [7:0] T2WO_CTRL_SECOND_RMASK = 8'h0f;

	// status and mask bit positions
	localparam int T2WO_ST_OVF       = 0;
	localparam int T2WO_ST_MATCH_A   = 1;
	localparam int T2WO_ST_MATCH_B   = 2;

	// counter landmarks
	localparam logic [7:0] T2WO_CNT_MAX    = 8'hff;
	localparam logic [7:0] T2WO_CNT_BOTTOM = 8'h00;

	// waveform mode numbers
	localparam logic [2:0] T2WO_WM_NORMAL  = 3'h0;
	localparam logic [2:0] T2WO_WM_PC_MAX  = 3'h1;
	localparam logic [2:0] T2WO_WM_CTC     = 3'h2;
	localparam logic [2:0] T2WO_WM_FAST_MAX = 3'h3;
	localparam logic [2:0] T2WO_WM_PC_CMP  = 3'h5;
	localparam logic [2:0] T2WO_WM_FAST_CMP = 3'h7;

	typedef enum logic [3:0] {
		T2WO_K_NORMAL = 4'b0001,
		T2WO_K_PC     = 4'b0010,
		T2WO_K_CTC    = 4'b0100,
		T2WO_K_FAST   = 4'b1000
	} t2wo_kind_t;

	// counter state as seen by the compare logic
	typedef struct packed {
		logic       tick;
		logic       down;
		logic [7:0] value;
	} t2wo_cnt_t;

	// one compare output: level and port override
	typedef struct packed {
		logic pin;
		logic over;
	} t2wo_wave_t;

endpackage

// *** rtl/t2wo_channel.sv ***
/*
 * one compare output channel: double-buffered compare value and the
 * output level action for each waveform kind.
 * assumes the counter state is synchronous to mclk_i.
 */
module t2wo_channel #(
	parameter bit IS_CH_A = 1'b1
) (
	input  wire logic                  mclk_i,
	input  wire logic                  resetn_i,
	input  wire t2wo_pkg::t2wo_kind_t  kind_i,
	input  wire logic [1:0]            com_i,
	input  wire logic                  wgm_top_i,
	input  wire t2wo_pkg::t2wo_cnt_t   cnt_i,
	input  wire logic [7:0]            top_i,
	input  wire logic                  wr_i,
	input  wire logic [7:0]            wdata_i,
	input  wire logic                  force_i,
	output logic [7:0]                 buf_o,
	output logic [7:0]                 cmp_o,
	output logic                       match_o,
	output t2wo_pkg::t2wo_wave_t       wave_o
);
	import t2wo_pkg::*;

	logic [7:0] buf_r;
	logic [7:0] cmp_r;
	logic       pin_r;
	logic       pin_nxt;
	logic       over_r;
	logic       pwm;
	logic       hit;
	logic       at_top;
	logic       at_bot;
	logic       ignore;
	logic       toggle_ok;

	assign pwm       = (kind_i == T2WO_K_PC) || (kind_i == T2WO_K_FAST);
	assign hit       = cnt_i.tick && (cnt_i.value == cmp_r);
	assign at_top    = cnt_i.tick && (cnt_i.value == top_i);
	assign at_bot    = cnt_i.tick && (cnt_i.value == T2WO_CNT_BOTTOM);
	assign ignore    = pwm && com_i[1] && (cmp_r == top_i);
	// channel b has no toggle in pwm kinds
	assign toggle_ok = !pwm || (IS_CH_A && wgm_top_i);

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			buf_r <= T2WO_RST_CMP;
		end else if (wr_i) begin
			buf_r <= wdata_i;
		end
	end

	// active compare value: immediate, at top or at bottom
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			cmp_r <= T2WO_RST_CMP;
		end else if (!pwm) begin
			cmp_r <= wr_i ? wdata_i : buf_r;
		end else if (kind_i == T2WO_K_PC && at_top) begin
			cmp_r <= buf_r;
		end else if (kind_i == T2WO_K_FAST && at_bot) begin
			cmp_r <= buf_r;
		end
	end

	always_comb begin
		pin_nxt = pin_r;
		case (kind_i)
			T2WO_K_FAST: begin
				if (at_bot && com_i[1]) begin
					pin_nxt = !com_i[0];
				end
				if (hit && !ignore) begin
					if (com_i == 2'b01 && toggle_ok) begin
						pin_nxt = !pin_r;
					end else if (com_i[1]) begin
						pin_nxt = com_i[0];
					end
				end
			end
			T2WO_K_PC: begin
				if (hit && !ignore) begin
					if (com_i == 2'b01 && toggle_ok) begin
						pin_nxt = !pin_r;
					end else if (com_i[1]) begin
						pin_nxt = com_i[0] ^ cnt_i.down;
					end
				end else if (at_top && ignore) begin
					pin_nxt = !com_i[0];
				end
			end
			default: begin
				if (hit || force_i) begin
					case (com_i)
						2'b01: pin_nxt = !pin_r;
						2'b10: pin_nxt = 1'b0;
						2'b11: pin_nxt = 1'b1;
						default: pin_nxt = pin_r;
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			pin_r  <= 1'b0;
			over_r <= 1'b0;
		end else begin
			pin_r  <= pin_nxt;
			over_r <= com_i[1] || (com_i[0] && toggle_ok);
		end
	end

	assign buf_o       = buf_r;
	assign cmp_o       = cmp_r;
	assign match_o     = hit;
	assign wave_o.pin  = pin_r;
	assign wave_o.over = over_r;

endmodule

// *** rtl/t2wo_top.sv ***
/*
 * waveform output control of the 8-bit timer: control registers,
 * waveform mode decode, two compare channels, flags and interrupt.
 * assumes an external counter driving cnt_i and honouring top_o, and
 * port logic that gates the pins with its own direction bits.
 */
// Decided for this implementation: the plain strobed port.
// Notes on behaviour
// - nonzero output mode takes over the pin, except 01 in pwm kinds without a toggle
// - channel a non-pwm: off, toggle, clear, set
// - fast pwm a mode 01 toggles only if top bit
// - fast pwm a 10/11 non-inverting or inverting
// - fast pwm compare equal top: bottom only
// - phase-correct a 10/11 by count direction
// - phase-correct a mode 01 toggles only if top bit
// - phase-correct compare equal top: act at top
// - channel b non-pwm same as channel a
// - fast pwm b: 01 reserved, 10/11 as a
// - phase-correct b: 01 reserved, 10/11 as a
// - first control bits 3 and 2 read zero
// - three mode bits across both control registers
// - mode encoding with top source per mode
// - second control register layout, strobes read zero
module t2wo_top (
	input  wire logic                  mclk_i,
	input  wire logic                  resetn_i,
	input  wire logic [7:0]            addr_i,
	input  wire logic [7:0]            wdata_i,
	input  wire logic                  wr_i,
	input  wire logic                  rd_i,
	output logic [7:0]                 rdata_o,
	input  wire t2wo_pkg::t2wo_cnt_t   cnt_i,
	output logic [7:0]                 top_o,
	output t2wo_pkg::t2wo_kind_t       kind_o,
	output logic [2:0]                 clock_source_select_o,
	output t2wo_pkg::t2wo_wave_t       channel_a_output_pin_o,
	output t2wo_pkg::t2wo_wave_t       channel_b_output_pin_o,
	output logic                       irq_o
);
	import t2wo_pkg::*;

	logic [7:0] ctrl_first_r;
	logic [7:0] ctrl_second_r;
	logic [2:0] stat_r;
	logic [2:0] mask_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [1:0] channel_a_output_mode;
	logic [1:0] channel_b_output_mode;
	logic       waveform_mode_top_bit;
	logic [2:0] waveform_mode_field;
	t2wo_kind_t kind;
	logic       pwm;
	logic       top_from_a;
	logic [7:0] top;
	logic       ovf_evt;
	logic       force_a;
	logic       force_b;
	logic       match_a;
	logic       match_b;
	logic [7:0] cmp_a;
	logic [7:0] cmp_b;
	logic [7:0] buf_a;
	logic [7:0] buf_b;
	logic [2:0] stat_set;
	logic [2:0] stat_clr;
	logic       wr_first;
	logic       wr_second;
	t2wo_wave_t wave_a;
	t2wo_wave_t wave_b;

	assign wr_first  = wr_i && (addr_i == T2WO_OFS_CTRL_FIRST);
	assign wr_second = wr_i && (addr_i == T2WO_OFS_CTRL_SECOND);

	assign channel_a_output_mode = ctrl_first_r[T2WO_COM_A_LSB +: 2];
	assign channel_b_output_mode = ctrl_first_r[T2WO_COM_B_LSB +: 2];
	assign waveform_mode_top_bit = ctrl_second_r[T2WO_WGM_TOP_BIT];
	assign waveform_mode_field   = {waveform_mode_top_bit,
		ctrl_first_r[T2WO_WGM_LOW_LSB +: 2]};

	// reserved bits are never stored, so they read zero
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			ctrl_first_r <= T2WO_RST_CTRL_FIRST;
		end else if (wr_first) begin
			ctrl_first_r <= wdata_i & T2WO_CTRL_FIRST_RMASK;
		end
	end

	// force strobes are not stored: they act in the write cycle only
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			ctrl_second_r <= T2WO_RST_CTRL_SECOND;
		end else if (wr_second) begin
			ctrl_second_r <= wdata_i & T2WO_CTRL_SECOND_RMASK;
		end
	end

	// modes 4 and 6 are reserved and behave as normal counting
	always_comb begin
		kind       = T2WO_K_NORMAL;
		top_from_a = 1'b0;
		case (waveform_mode_field)
			T2WO_WM_PC_MAX: kind = T2WO_K_PC;
			T2WO_WM_CTC: begin
				kind       = T2WO_K_CTC;
				top_from_a = 1'b1;
			end
			T2WO_WM_FAST_MAX: kind = T2WO_K_FAST;
			T2WO_WM_PC_CMP: begin
				kind       = T2WO_K_PC;
				top_from_a = 1'b1;
			end
			T2WO_WM_FAST_CMP: begin
				kind       = T2WO_K_FAST;
				top_from_a = 1'b1;
			end
			default: kind = T2WO_K_NORMAL;
		endcase
	end

	assign pwm = (kind == T2WO_K_PC) || (kind == T2WO_K_FAST);
	assign top = top_from_a ? cmp_a : T2WO_CNT_MAX;

	// force acts only outside pwm kinds and raises no flag
	assign force_a = wr_second && wdata_i[T2WO_FORCE_A_BIT] && !pwm;
	assign force_b = wr_second && wdata_i[T2WO_FORCE_B_BIT] && !pwm;

	// overflow point per mode
	always_comb begin
		ovf_evt = 1'b0;
		if (cnt_i.tick) begin
			case (waveform_mode_field)
				T2WO_WM_PC_MAX, T2WO_WM_PC_CMP:
					ovf_evt = (cnt_i.value == T2WO_CNT_BOTTOM);
				T2WO_WM_FAST_CMP:
					ovf_evt = (cnt_i.value == top);
				default:
					ovf_evt = (cnt_i.value == T2WO_CNT_MAX);
			endcase
		end
	end

	t2wo_channel #(
		.IS_CH_A (1'b1)
	) u_chan_a (
		.mclk_i    (mclk_i),
		.resetn_i  (resetn_i),
		.kind_i    (kind),
		.com_i     (channel_a_output_mode),
		.wgm_top_i (waveform_mode_top_bit),
		.cnt_i     (cnt_i),
		.top_i     (top),
		.wr_i      (wr_i && addr_i == T2WO_OFS_CMP_A),
		.wdata_i   (wdata_i),
		.force_i   (force_a),
		.buf_o     (buf_a),
		.cmp_o     (cmp_a),
		.match_o   (match_a),
		.wave_o    (wave_a)
	);

	t2wo_channel #(
		.IS_CH_A (1'b0)
	) u_chan_b (
		.mclk_i    (mclk_i),
		.resetn_i  (resetn_i),
		.kind_i    (kind),
		.com_i     (channel_b_output_mode),
		.wgm_top_i (waveform_mode_top_bit),
		.cnt_i     (cnt_i),
		.top_i     (top),
		.wr_i      (wr_i && addr_i == T2WO_OFS_CMP_B),
		.wdata_i   (wdata_i),
		.force_i   (force_b),
		.buf_o     (buf_b),
		.cmp_o     (cmp_b),
		.match_o   (match_b),
		.wave_o    (wave_b)
	);

	// sticky flags, write one to clear, a new event wins over the clear
	always_comb begin
		stat_set = 3'h0;
		stat_set[T2WO_ST_OVF]     = ovf_evt;
		stat_set[T2WO_ST_MATCH_A] = match_a;
		stat_set[T2WO_ST_MATCH_B] = match_b;
		stat_clr = 3'h0;
		if (wr_i && addr_i == T2WO_OFS_IRQ_STAT) begin
			stat_clr = wdata_i[2:0];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			stat_r <= T2WO_RST_IRQ;
		end else begin
			stat_r <= (stat_r & ~stat_clr) | stat_set;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			mask_r <= T2WO_RST_IRQ;
		end else if (wr_i && addr_i == T2WO_OFS_IRQ_MASK) begin
			mask_r <= wdata_i[2:0];
		end
	end

	// read data stand in the cycle after the read strobe only
	always_comb begin
		rdata_nxt = 8'h00;
		if (!rd_i) begin
			rdata_nxt = 8'h00;
		end else if (addr_i == T2WO_OFS_CTRL_FIRST) begin
			rdata_nxt = ctrl_first_r;
		end else if (addr_i == T2WO_OFS_CTRL_SECOND) begin
			rdata_nxt = ctrl_second_r;
		end else if (addr_i == T2WO_OFS_CMP_A) begin
			rdata_nxt = buf_a;
		end else if (addr_i == T2WO_OFS_CMP_B) begin
			rdata_nxt = buf_b;
		end else if (addr_i == T2WO_OFS_IRQ_STAT) begin
			rdata_nxt = {5'h00, stat_r};
		end else if (addr_i == T2WO_OFS_IRQ_MASK) begin
			rdata_nxt = {5'h00, mask_r};
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata_o                = rdata_r;
	assign top_o                  = top;
	assign kind_o                 = kind;
	assign clock_source_select_o  = ctrl_second_r[T2WO_CS_LSB +: 3];
	assign channel_a_output_pin_o = wave_a;
	assign channel_b_output_pin_o = wave_b;
	assign irq_o                  = |(stat_r & mask_r);

	// checks
	logic hit_a;
	logic hit_b;
	assign hit_a = cnt_i.tick && cnt_i.value == cmp_a;
	assign hit_b = cnt_i.tick && cnt_i.value == cmp_b;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	override_a: assert property (
		!pwm && channel_a_output_mode != 2'b00 |=> wave_a.over)
		else $error("channel a override missing");

	toggle_a: assert property (
		!pwm && channel_a_output_mode == 2'b01 && hit_a && !force_a
		|=> wave_a.pin != $past(wave_a.pin))
		else $error("channel a did not toggle on match");

	clear_a: assert property (
		!pwm && channel_a_output_mode == 2'b10 && hit_a |=> !wave_a.pin)
		else $error("channel a not cleared on match");

	fast_off_a: assert property (
		kind == T2WO_K_FAST && channel_a_output_mode == 2'b01
		&& !waveform_mode_top_bit && !wr_first && !wr_second
		|=> $stable(wave_a.pin) && !wave_a.over)
		else $error("fast pwm mode 01 acted without top bit");

	fast_bot_a: assert property (
		kind == T2WO_K_FAST && channel_a_output_mode == 2'b10
		&& cnt_i.tick && cnt_i.value == T2WO_CNT_BOTTOM
		&& cmp_a != T2WO_CNT_BOTTOM |=> wave_a.pin)
		else $error("fast pwm not set at bottom");

	fast_ign_a: assert property (
		kind == T2WO_K_FAST && channel_a_output_mode == 2'b10
		&& cmp_a == top && hit_a && cnt_i.value != T2WO_CNT_BOTTOM
		|=> $stable(wave_a.pin))
		else $error("fast pwm match at top not ignored");

	pc_up_a: assert property (
		kind == T2WO_K_PC && channel_a_output_mode == 2'b10 && hit_a
		&& !cnt_i.down && cmp_a != top |=> !wave_a.pin)
		else $error("phase correct up match did not clear");

	pc_dn_a: assert property (
		kind == T2WO_K_PC && channel_a_output_mode == 2'b11 && hit_a
		&& cnt_i.down && cmp_a != top |=> !wave_a.pin)
		else $error("phase correct down match did not clear");

	pc_top_a: assert property (
		kind == T2WO_K_PC && channel_a_output_mode == 2'b10
		&& cmp_a == top && cnt_i.tick && cnt_i.value == top
		|=> wave_a.pin)
		else $error("phase correct top action missing");

	set_b_a: assert property (
		!pwm && channel_b_output_mode == 2'b11 && hit_b |=> wave_b.pin)
		else $error("channel b not set on match");

	clear_b_a: assert property (
		!pwm && channel_b_output_mode == 2'b10 && hit_b |=> !wave_b.pin)
		else $error("channel b not cleared on match");

	fast_bot_b_a: assert property (
		kind == T2WO_K_FAST && channel_b_output_mode == 2'b10
		&& cnt_i.tick && cnt_i.value == T2WO_CNT_BOTTOM
		&& cmp_b != T2WO_CNT_BOTTOM |=> wave_b.pin)
		else $error("channel b not set at bottom");

	resv_b_a: assert property (
		pwm && channel_b_output_mode == 2'b01 && !wr_first
		&& !wr_second ##1 pwm |-> $stable(wave_b.pin) && !wave_b.over)
		else $error("reserved channel b mode acted");

	resv_read_a: assert property (
		rd_i && addr_i == T2WO_OFS_CTRL_FIRST |=> rdata_o[3:2] == 2'b00)
		else $error("reserved bits read nonzero");

	ctrl2_read_a: assert property (
		rd_i && addr_i == T2WO_OFS_CTRL_SECOND
		|=> rdata_o[7:4] == 4'h0 && rdata_o[3] == $past(waveform_mode_top_bit))
		else $error("second control readback wrong");

	mode_decode_a: assert property (
		wr_second && wdata_i[T2WO_WGM_TOP_BIT] ##1
		ctrl_first_r[1:0] == 2'b01 |-> kind == T2WO_K_PC && top_o == cmp_a)
		else $error("mode 5 decode wrong");

	ovf_flag_a: assert property (
		waveform_mode_field == T2WO_WM_FAST_MAX && cnt_i.tick
		&& cnt_i.value == T2WO_CNT_MAX |=> stat_r[T2WO_ST_OVF])
		else $error("overflow flag not set at max");

	fast_cover: cover property (kind == T2WO_K_FAST && hit_a ##[1:300]
		cnt_i.tick && cnt_i.value == T2WO_CNT_BOTTOM);
	pc_cover: cover property (kind == T2WO_K_PC && hit_a && cnt_i.down);
	force_cover: cover property (force_a && channel_a_output_mode != 2'b00);
	irq_cover: cover property ($rose(irq_o));

endmodule

// *** verif/t2wo_pad_model.sv ***
/*
 * pad behind one compare output: port logic with a direction bit and a
 * pull-up while nothing drives the pad.
 * assumes the wave carrier of the timer block and a static port level.
 */
module t2wo_pad_model (
	input  wire logic                 dir_i,
	input  wire logic                 port_i,
	input  wire t2wo_pkg::t2wo_wave_t wave_i,
	output logic                      pad_o
);
	import t2wo_pkg::*;
	// no driver without the direction bit, whatever the override says
	assign pad_o = !dir_i ? 1'b1
		: (wave_i.over ? wave_i.pin : port_i);
endmodule

// *** verif/tb_t2wo_top.sv ***
/*
 * self-checking bench for the waveform output control: registers,
 * mode decode, compare actions per kind, flags, interrupt and pad.
 * assumes the package constants and the pad model on channel a.
 */
module tb_t2wo_top;
	timeunit 1ns;
	timeprecision 1ns;
	import t2wo_pkg::*;

	localparam logic [7:0] CTL1 = T2WO_OFS_CTRL_FIRST;
	localparam logic [7:0] CTL2 = T2WO_OFS_CTRL_SECOND;
	localparam logic [7:0] CA   = T2WO_OFS_CMP_A;
	localparam logic [7:0] CB   = T2WO_OFS_CMP_B;
	localparam logic [7:0] ST   = T2WO_OFS_IRQ_STAT;
	localparam logic [7:0] MK   = T2WO_OFS_IRQ_MASK;

	logic       mclk, resetn, wr, rd, dir, irq, pad, pa;
	logic [7:0] addr, wdata, rdata, top;
	logic [2:0] css;
	t2wo_cnt_t  cnt;
	t2wo_kind_t kind;
	t2wo_wave_t wa, wb;
	int         errors, tests_run;

	t2wo_top dut_u (
		.mclk_i(mclk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cnt_i(cnt), .top_o(top),
		.kind_o(kind), .clock_source_select_o(css),
		.channel_a_output_pin_o(wa), .channel_b_output_pin_o(wb),
		.irq_o(irq)
	);

	t2wo_pad_model pad_u (
		.dir_i(dir), .port_i(1'b1), .wave_i(wa), .pad_o(pad)
	);

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic chk(input string name, input logic [7:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic wreg(input logic [7:0] a, d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rreg(input logic [7:0] a, exp, input string name);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(name, rdata, exp);
	endtask

	task automatic tick(input logic [7:0] v, input logic dn);
		@(posedge mclk);
		cnt <= '{tick: 1'b1, down: dn, value: v};
		@(posedge mclk);
		cnt.tick <= 1'b0;
		#1;
	endtask

	// pin and override of both channels in one compare
	task automatic pins(input logic ea, eb, oa, ob);
		chk("pins", {4'h0, wa, wb}, {4'h0, ea, oa, eb, ob});
	endtask

	task automatic chk_over(input logic oa, ob);
		chk("override", {6'h0, wa.over, wb.over}, {6'h0, oa, ob});
	endtask

	task automatic s_reset();
		logic [7:0] ofs [6] = '{CTL1, CTL2, CA, CB, ST, MK};
		chk("top", top, T2WO_CNT_MAX);
		chk("kind", {4'h0, kind}, {4'h0, T2WO_K_NORMAL});
		pins(1'b0, 1'b0, 1'b0, 1'b0);
		wreg(8'h00, 8'hff);
		rreg(8'h00, 8'h00, "unmapped");
		foreach (ofs[i])
			rreg(ofs[i], 8'h00, "reset value");
	endtask

	task automatic s_regs();
		wreg(CTL1, 8'hff);
		rreg(CTL1, 8'hf3, "first control");
		wreg(CTL2, 8'h3f);
		rreg(CTL2, 8'h0f, "second control");
		chk("clock select", {5'h0, css}, 8'h07);
		wreg(CTL1, 8'h00);
	endtask

	task automatic s_modes();
		t2wo_kind_t k [8] = '{T2WO_K_NORMAL, T2WO_K_PC, T2WO_K_CTC,
			T2WO_K_FAST, T2WO_K_NORMAL, T2WO_K_PC, T2WO_K_NORMAL,
			T2WO_K_FAST};
		wreg(CTL2, 8'h00);
		wreg(CA, 8'h40);
		rreg(CA, 8'h40, "compare a");
		for (int m = 0; m < 8; m++) begin
			wreg(CTL2, {4'h0, m[2], 3'h0});
			wreg(CTL1, {6'h0, m[1:0]});
			chk("kind", {4'h0, kind}, {4'h0, k[m]});
			chk("top", top, (m inside {2, 5, 7}) ? 8'h40 : 8'hff);
		end
		wreg(CTL2, 8'h00);
	endtask

	task automatic s_nonpwm();
		wreg(CTL1, 8'h00);
		wreg(CA, 8'h05);
		wreg(CB, 8'h09);
		wreg(MK, 8'h06);
		for (int c = 1; c < 4; c++) begin
			wreg(CTL1, {c[1:0], c[1:0], 4'h0});
			pa = (c == 1) ? ~pa : c[0];
			tick(8'h05, 1'b0);
			tick(8'h09, 1'b0);
			pins(pa, pa, 1'b1, 1'b1);
			chk("irq raised", {7'h0, irq}, 8'h01);
			rreg(ST, 8'h06, "status");
			wreg(ST, 8'h06);
			chk("irq cleared", {7'h0, irq}, 8'h00);
		end
		wreg(MK, 8'h00);
		tick(8'h05, 1'b0);
		chk("irq masked", {7'h0, irq}, 8'h00);
		rreg(ST, 8'h02, "status");
		wreg(ST, 8'h02);
		// forced match toggles channel a only, without a flag
		wreg(CTL1, 8'h40);
		wreg(CTL2, 8'h80);
		@(posedge mclk);
		#1;
		pins(1'b0, 1'b1, 1'b1, 1'b0);
		rreg(ST, 8'h00, "status");
		rreg(CTL2, 8'h00, "second control");
		chk("pad undriven", {7'h0, pad}, 8'h01);
		@(posedge mclk);
		dir <= 1'b1;
		#1;
		chk("pad driven", {7'h0, pad}, 8'h00);
	endtask

	task automatic s_fast();
		wreg(CTL1, 8'hf3);
		wreg(CA, 8'h20);
		wreg(CB, 8'hff);
		tick(8'h00, 1'b0);
		pins(1'b0, 1'b0, 1'b1, 1'b1);
		tick(8'h20, 1'b0);
		tick(8'hff, 1'b0);
		pins(1'b1, 1'b0, 1'b1, 1'b1);
		wreg(CTL1, 8'ha3);
		tick(8'h00, 1'b0);
		pins(1'b1, 1'b1, 1'b1, 1'b1);
		tick(8'h20, 1'b0);
		tick(8'hff, 1'b0);
		pins(1'b0, 1'b1, 1'b1, 1'b1);
		rreg(ST, 8'h07, "status");
		wreg(CTL1, 8'h53);
		// override is registered: it follows the mode one edge later
		@(posedge mclk);
		#1;
		chk_over(1'b0, 1'b0);
		tick(8'hff, 1'b0);
		wreg(ST, 8'h07);
		wreg(CTL2, 8'h08);
		chk("top", top, 8'h20);
		tick(8'h20, 1'b0);
		pins(1'b1, 1'b1, 1'b1, 1'b0);
		rreg(ST, 8'h03, "status");
		// channel a compare is top in mode 7: its match must not clear
		wreg(CTL1, 8'ha3);
		tick(8'h20, 1'b0);
		pins(1'b1, 1'b1, 1'b1, 1'b1);
	endtask

	task automatic s_phase();
		wreg(CTL2, 8'h00);
		wreg(CTL1, 8'hf1);
		wreg(CA, 8'h30);
		wreg(ST, 8'h07);
		tick(8'hff, 1'b0);
		pins(1'b1, 1'b0, 1'b1, 1'b1);
		rreg(ST, 8'h04, "status");
		tick(8'h30, 1'b1);
		pins(1'b0, 1'b0, 1'b1, 1'b1);
		tick(8'h00, 1'b1);
		rreg(ST, 8'h07, "status");
		tick(8'h30, 1'b0);
		wreg(CTL1, 8'ha1);
		tick(8'h30, 1'b0);
		tick(8'hff, 1'b0);
		pins(1'b0, 1'b1, 1'b1, 1'b1);
		tick(8'h30, 1'b1);
		pins(1'b1, 1'b1, 1'b1, 1'b1);
		wreg(CTL1, 8'h51);
		@(posedge mclk);
		#1;
		chk_over(1'b0, 1'b0);
		wreg(CTL2, 8'h08);
		tick(8'h30, 1'b0);
		pins(1'b0, 1'b1, 1'b1, 1'b0);
		// compare a equals top in mode 5: mode 10 sets at top
		wreg(CTL1, 8'ha1);
		tick(8'h30, 1'b0);
		pins(1'b1, 1'b1, 1'b1, 1'b1);
	endtask

	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		resetn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		dir = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		cnt = '0;
		pa = 1'b0;
		errors = 0;
		tests_run = 0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		#1;
		s_reset();
		s_regs();
		s_modes();
		s_nonpwm();
		s_fast();
		s_phase();
		test_done();
	end

	// the sequence needs about two hundred cycles; this is far beyond
	initial begin
		#100000;
		errors++;
		test_done();
	end
endmodule
